// [hdl/sbt_tap.sv]
// boundary-scan test access port of a burst sram
// tck arrives as a plain pin sampled by clock_i; ring values come from the pin pads
// How it works
// - tms sampled each tck rise steers the port; open tms reads high
// - inputs taken on tck rise, tdo changed on tck fall
// - open tdi reads high via pull-up
// - selected register shifts in at msb, out at lsb
// - exactly one register between tdi and tdo, chosen by instruction
// - tdo driven only in shift states, else high impedance
// - five tck rises with tms high reach reset from any state
// - port reset never touches memory operation
// - power-up resets the port with tdo released
// - three-bit instruction register loaded serially in shift-ir
// - power-up and port reset preset the identification instruction
// - capture-ir loads binary 01 into the two low bits
// - one-bit bypass register, cleared when bypass executes
// - boundary register holds one cell per pin plus reserved cells
// - capture-dr loads the pin ring, shift-dr shifts it
// - extest, sample and sample-z all select and capture the ring
// - all-zero code acts as sample, never drives pins
// - identification instruction captures a fixed 32-bit value
// - update-dr under sample changes nothing, like pause
// - bypass routes tdi to tdo through the bypass bit
`timescale 1ns/1ps
module sbt_tap
   import sbt_pkg::*;
#(
   parameter int             BSR_W   = SBT_BSR_W,
   // arbitrary identification value, not any maker's code
   parameter logic [31:0]    ID_CODE = 32'h0000_0001
) (
   input  wire logic             clock_i,
   input  wire logic             rst_b_i,
   input  wire logic             ce_i,
   input  wire logic             tck_i,
   input  wire logic             tms_i,
   input  wire logic             tdi_i,
   input  wire logic [BSR_W-1:0] ring_i,
   output logic                  tdo_o,
   output logic                  tdo_oe_o,
   output logic [SBT_IR_W-1:0]   instr_o,
   output logic [3:0]            state_o
);

   // refuse shapes the shift path cannot serve
   if (BSR_W < 2) begin : g_bsr_w_chk
      $error("boundary register too short");
   end
   if (ID_CODE[0] != 1'b1) begin : g_id_chk
      $error("id lsb must mark presence");
   end

   logic [2:0]           pins;
   logic                 tck_rise;
   logic                 tck_fall;
   logic                 tms;
   logic                 tdi;
   sbt_state_e           state_q;
   sbt_state_e           state_d;
   logic [SBT_IR_W-1:0]  ir_sh_q;
   logic [SBT_IR_W-1:0]  ir_q;
   logic                 byp_q;
   logic [SBT_ID_W-1:0]  id_q;
   logic [BSR_W-1:0]     bsr_q;
   logic                 tdo_q;
   logic                 tdo_oe_q;
   logic                 ser_bit;
   logic                 sel_bsr;
   logic                 sel_id;
   logic [BSR_W-1:0]     ring_s;

   // bit0 tck, bit1 tms, bit2 tdi; pull-ups are the board's, logic just samples
   sbt_pin_sync #(
      .W (3)
   ) u_sync (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .ce_i    (ce_i),
      .pin_i   ({tdi_i, tms_i, tck_i}),
      .level_o (pins),
      .rise_o  (tck_rise),
      .fall_o  (tck_fall)
   );

   assign tms = pins[1];
   assign tdi = pins[2];

   // ring bits move with the sram's own clock; two flops keep metastable values
   // away from the capture mux, and the two-cycle lag is far below one tck period.
   // the ring is only read here, nothing reaches the memory core
   sbt_pin_sync #(
      .W (BSR_W)
   ) u_ring_sync (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .ce_i    (ce_i),
      .pin_i   (ring_i),
      .level_o (ring_s),
      .rise_o  (),
      .fall_o  ()
   );

   // port sequence; five tms-high rises reach reset from anywhere
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         SBT_TLR:      state_d = tms ? SBT_TLR      : SBT_RTI;
         SBT_RTI:      state_d = tms ? SBT_SEL_DR   : SBT_RTI;
         SBT_SEL_DR:   state_d = tms ? SBT_SEL_IR   : SBT_CAP_DR;
         SBT_CAP_DR:   state_d = tms ? SBT_EXIT1_DR : SBT_SHIFT_DR;
         SBT_SHIFT_DR: state_d = tms ? SBT_EXIT1_DR : SBT_SHIFT_DR;
         SBT_EXIT1_DR: state_d = tms ? SBT_UPD_DR   : SBT_PAUSE_DR;
         SBT_PAUSE_DR: state_d = tms ? SBT_EXIT2_DR : SBT_PAUSE_DR;
         SBT_EXIT2_DR: state_d = tms ? SBT_UPD_DR   : SBT_SHIFT_DR;
         SBT_UPD_DR:   state_d = tms ? SBT_SEL_DR   : SBT_RTI;
         SBT_SEL_IR:   state_d = tms ? SBT_TLR      : SBT_CAP_IR;
         SBT_CAP_IR:   state_d = tms ? SBT_EXIT1_IR : SBT_SHIFT_IR;
         SBT_SHIFT_IR: state_d = tms ? SBT_EXIT1_IR : SBT_SHIFT_IR;
         SBT_EXIT1_IR: state_d = tms ? SBT_UPD_IR   : SBT_PAUSE_IR;
         SBT_PAUSE_IR: state_d = tms ? SBT_EXIT2_IR : SBT_PAUSE_IR;
         SBT_EXIT2_IR: state_d = tms ? SBT_UPD_IR   : SBT_SHIFT_IR;
         SBT_UPD_IR:   state_d = tms ? SBT_SEL_DR   : SBT_RTI;
      endcase
   end

   // power-up reset is the async reset; no tms sequence needed
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= SBT_TLR;
      end else if (ce_i && tck_rise) begin
         state_q <= state_d;
      end
   end

   // instruction register: shift stage plus held instruction
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ir_sh_q <= SBT_INS_IDCODE;
         ir_q    <= SBT_INS_IDCODE;
      end else if (ce_i && tck_rise) begin
         // preset on the very rise that enters reset, not one tck later
         if (state_d == SBT_TLR) begin
            ir_q <= SBT_INS_IDCODE;
         end
         unique case (state_q)
            SBT_CAP_IR:   ir_sh_q <= {ir_sh_q[SBT_IR_W-1:2], SBT_IR_CAPTURE};
            SBT_SHIFT_IR: ir_sh_q <= {tdi, ir_sh_q[SBT_IR_W-1:1]};
            SBT_UPD_IR:   ir_q    <= ir_sh_q;
            default: begin
            end
         endcase
      end
   end

   // extest is treated as sample: capture only, no pin drive exists at all
   assign sel_bsr = (ir_q == SBT_INS_EXTEST) || (ir_q == SBT_INS_SAMPLE)
                  || (ir_q == SBT_INS_SAMPLE_Z);
   assign sel_id  = (ir_q == SBT_INS_IDCODE);
   // anything else, including reserved codes, falls to bypass

   // bypass bit
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         byp_q <= 1'b0;
      end else if (ce_i && tck_rise && !sel_bsr && !sel_id) begin
         if (state_q == SBT_CAP_DR) begin
            byp_q <= 1'b0;
         end else if (state_q == SBT_SHIFT_DR) begin
            byp_q <= tdi;
         end
      end
   end

   // identification register
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         id_q <= '0;
      end else if (ce_i && tck_rise && sel_id) begin
         if (state_q == SBT_CAP_DR) begin
            id_q <= ID_CODE;
         end else if (state_q == SBT_SHIFT_DR) begin
            id_q <= {tdi, id_q[SBT_ID_W-1:1]};
         end
      end
   end

   // boundary ring; ring values may be in motion, capture is best effort.
   // update-dr has no hook here, so it behaves as pause
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bsr_q <= '0;
      end else if (ce_i && tck_rise && sel_bsr) begin
         if (state_q == SBT_CAP_DR) begin
            bsr_q <= ring_s;
         end else if (state_q == SBT_SHIFT_DR) begin
            bsr_q <= {tdi, bsr_q[BSR_W-1:1]};
         end
      end
   end

   // one source feeds tdo at a time
   always_comb begin
      if (state_q == SBT_SHIFT_IR) begin
         ser_bit = ir_sh_q[0];
      end else if (sel_bsr) begin
         ser_bit = bsr_q[0];
      end else if (sel_id) begin
         ser_bit = id_q[0];
      end else begin
         ser_bit = byp_q;
      end
   end

   // launch on tck fall; enable only while shifting
   // limitation: tdo lags the pin fall by about three clocks
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tdo_q    <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else if (ce_i && tck_fall) begin
         tdo_q    <= ser_bit;
         tdo_oe_q <= (state_q == SBT_SHIFT_DR) || (state_q == SBT_SHIFT_IR);
      end
   end

   assign tdo_o    = tdo_q;
   assign tdo_oe_o = tdo_oe_q;
   assign instr_o  = ir_q;
   assign state_o  = state_q;

   // five rises with tms high always land in reset
   logic [2:0] tms_run_q;
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tms_run_q <= '0;
      end else if (ce_i && tck_rise) begin
         if (!tms) begin
            tms_run_q <= 3'h0;
         end else if (tms_run_q != 3'(SBT_RESET_TMS_N)) begin
            tms_run_q <= tms_run_q + 3'h1;
         end
      end
   end

   a_tms_reset_reach: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      tms_run_q == 3'(SBT_RESET_TMS_N) |-> state_q == SBT_TLR) else $error("five tms highs did not reset port");

   a_reset_ir_id: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      state_q == SBT_TLR |-> ir_q == SBT_INS_IDCODE)
      else $error("reset did not preset identification");

   a_capir_pattern: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      state_q == SBT_CAP_IR && ce_i && tck_rise |=> ir_sh_q[1:0] == SBT_IR_CAPTURE)
      else $error("capture-ir pattern wrong");

   a_tdo_idle_off: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      tdo_oe_o && ce_i && tck_fall && state_q != SBT_SHIFT_DR && state_q != SBT_SHIFT_IR |=> !tdo_oe_o)
      else $error("tdo driven outside shift");

   a_tdo_on_fall: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      !(ce_i && tck_fall) |=> $stable(tdo_o) && $stable(tdo_oe_o))
      else $error("tdo moved without tck fall");

   a_id_capture: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      sel_id && state_q == SBT_CAP_DR && ce_i && tck_rise |=> id_q == ID_CODE)
      else $error("id value not captured");

   a_ring_capture: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      sel_bsr && state_q == SBT_CAP_DR && ce_i && tck_rise |=> bsr_q == $past(ring_s))
      else $error("ring not captured");

   a_bypass_clear: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      !sel_bsr && !sel_id && state_q == SBT_CAP_DR && ce_i && tck_rise |=> !byp_q)
      else $error("bypass not cleared");

   a_freeze_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      !ce_i |=> $stable(state_q)) else $error("state moved while frozen");

   // tck rises and falls that the checks below key on, as the state machine sees them
   sequence s_dr_shift_rise;
      ce_i && tck_rise && state_q == SBT_SHIFT_DR;
   endsequence

   sequence s_ir_shift_rise;
      ce_i && tck_rise && state_q == SBT_SHIFT_IR;
   endsequence

   sequence s_dr_update_rise;
      ce_i && tck_rise && state_q == SBT_UPD_DR;
   endsequence

   sequence s_ir_update_rise;
      ce_i && tck_rise && state_q == SBT_UPD_IR;
   endsequence

   sequence s_fall_seen;
      ce_i && tck_fall;
   endsequence

   // msb takes tdi, lsb takes what sat one place above it
   a_bsr_shift_in: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      s_dr_shift_rise ##0 sel_bsr |=> bsr_q[BSR_W-1] == $past(tdi) && bsr_q[0] == $past(bsr_q[1]))
      else $error("boundary register shift wrong");

   a_id_shift_in: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      s_dr_shift_rise ##0 sel_id |=> id_q[SBT_ID_W-1] == $past(tdi) && id_q[0] == $past(id_q[1]))
      else $error("id register shift wrong");

   a_ir_shift_in: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      s_ir_shift_rise |=> ir_sh_q[SBT_IR_W-1] == $past(tdi) && ir_sh_q[0] == $past(ir_sh_q[1]))
      else $error("instruction shift wrong");

   a_bypass_route: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      s_dr_shift_rise ##0 (!sel_bsr && !sel_id) |=> byp_q == $past(tdi))
      else $error("bypass bit did not take tdi");

   a_ir_update: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      s_ir_update_rise |=> ir_q == $past(ir_sh_q))
      else $error("instruction not updated");

   a_update_quiet: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      s_dr_update_rise ##0 sel_bsr |=> $stable(bsr_q))
      else $error("boundary register moved in update");

   a_tdo_launch: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      s_fall_seen |=> tdo_o == $past(ser_bit))
      else $error("tdo did not launch selected bit");

   a_oe_in_shift: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      s_fall_seen ##0 (state_q == SBT_SHIFT_DR || state_q == SBT_SHIFT_IR) |=> tdo_oe_o)
      else $error("tdo not driven while shifting");

   a_one_path: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      !(sel_bsr && sel_id)) else $error("two scan paths selected");

   a_tlr_leave: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      ce_i && tck_rise && state_q == SBT_TLR && !tms |=> state_q == SBT_RTI)
      else $error("reset state did not leave on tms low");

   a_freeze_regs: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      !ce_i |=> $stable(ir_q) && $stable(bsr_q) && $stable(tdo_o) && $stable(tdo_oe_o))
      else $error("registers moved while frozen");

endmodule // sbt_tap

// [pkg/sbt_pkg.sv]
// package for the boundary-scan test access port
// shared by the port top and its pin-edge sampler
package sbt_pkg;

   localparam int          SBT_IR_W         = 3;
   localparam int          SBT_ID_W         = 32;
   localparam int          SBT_BSR_W        = 107;
   localparam int          SBT_RESET_TMS_N  = 5;

   localparam logic [2:0]  SBT_INS_EXTEST   = 3'h0;
   localparam logic [2:0]  SBT_INS_IDCODE   = 3'h1;
   localparam logic [2:0]  SBT_INS_SAMPLE_Z = 3'h2;
   localparam logic [2:0]  SBT_INS_SAMPLE   = 3'h4;
   localparam logic [2:0]  SBT_INS_BYPASS   = 3'h7;
   localparam logic [1:0]  SBT_IR_CAPTURE   = 2'h1;

   // tck figures for the bench
   localparam int          SBT_CLK_NS       = 25;
   localparam int          SBT_TCK_MIN_NS   = 100;
   localparam int          SBT_TCK_MIN_CYC  = (SBT_TCK_MIN_NS + SBT_CLK_NS - 1) / SBT_CLK_NS;

   typedef enum logic [3:0] {
      SBT_TLR, SBT_RTI, SBT_SEL_DR, SBT_CAP_DR, SBT_SHIFT_DR, SBT_EXIT1_DR,
      SBT_PAUSE_DR, SBT_EXIT2_DR, SBT_UPD_DR, SBT_SEL_IR, SBT_CAP_IR,
      SBT_SHIFT_IR, SBT_EXIT1_IR, SBT_PAUSE_IR, SBT_EXIT2_IR, SBT_UPD_IR
   } sbt_state_e;

endpackage

// [hdl/sbt_pin_sync.sv]
// two-flop synchroniser and edge finder for the test pins
// assumes pins are asynchronous to clock_i
`timescale 1ns/1ps
module sbt_pin_sync
   import sbt_pkg::*;
#(
   parameter int W = 3
) (
   input  wire logic         clock_i,
   input  wire logic         rst_b_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] level_o,
   output logic              rise_o,
   output logic              fall_o
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic         clk_prev_q;

   if (W < 1) begin : g_w_chk
      $error("width must be at least one");
   end

   // reset low: matches tck's idle level, so no false edge follows reset
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (ce_i) begin
         meta_q <= pin_i;
         sync_q <= meta_q;
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         clk_prev_q <= 1'b0;
      end else if (ce_i) begin
         clk_prev_q <= sync_q[0];
      end
   end

   assign level_o = sync_q;
   assign rise_o  = sync_q[0] & ~clk_prev_q;
   assign fall_o  = ~sync_q[0] & clk_prev_q;

endmodule // sbt_pin_sync

// [verification/sbt_tap_master.sv]
// test master model: drives tck, tms and tdi, samples tdo
// assumes the port's clock_i; one tck period is 8 clocks (200 ns)
`timescale 1ns/1ps
module sbt_tap_master (
   input  wire logic clock_i,
   input  wire logic tdo_i,
   input  wire logic tdo_oe_i,
   output logic      tck_o,
   output logic      tms_o,
   output logic      tdi_o,
   output logic      rx_valid_o,
   output logic      rx_bit_o
);
   logic last_q = 1'b0;
   logic line;

   // a released tdo reads as a changing pattern, never held at the last driven bit
   assign line = tdo_oe_i ? tdo_i : ~last_q;

   always @(posedge clock_i) begin
      last_q <= line;
   end

   initial begin
      tck_o      = 1'b0; // still and low outside frames
      tms_o      = 1'b1; // open pins read high
      tdi_o      = 1'b1;
      rx_valid_o = 1'b0;
      rx_bit_o   = 1'b0;
   end

   // data set, tck rise 2 clocks later with tdo sampled, fall 4 clocks after that
   task automatic step(input logic tms_v, input logic tdi_v, input logic chk);
      @(posedge clock_i);
      tms_o <= tms_v; // held through the rise
      tdi_o <= tdi_v;
      repeat (2) @(posedge clock_i);
      tck_o      <= 1'b1;
      rx_bit_o   <= line;
      rx_valid_o <= chk;
      @(posedge clock_i);
      rx_valid_o <= 1'b0;
      repeat (3) @(posedge clock_i);
      tck_o <= 1'b0;
      @(posedge clock_i);
   endtask
endmodule // sbt_tap_master

// [verification/sbt_tap_test.sv]
// self-checking bench for the boundary-scan port
// assumes the master model drives the pins; ring values are random per capture
`timescale 1ns/1ps
module sbt_tap_test
   import sbt_pkg::*;
();
   // arbitrary identification value
   localparam logic [31:0] ID_VAL = 32'h5A3C_9E17;

   logic                 clock_i   = 1'b0;
   logic                 rst_b_i   = 1'b0;
   logic                 ce_i      = 1'b1;
   logic [SBT_BSR_W-1:0] ring      = '0;
   logic                 tck, tms, tdi, tdo, tdo_oe, rx_valid, rx_bit;
   logic [SBT_IR_W-1:0]  instr;
   logic [3:0]           state;
   logic                 exp_q[$];
   int                   error_cnt   = 0;
   int                   comparisons = 0;

   always #12.5 clock_i = ~clock_i;

   sbt_tap #(.BSR_W(SBT_BSR_W), .ID_CODE(ID_VAL)) dut (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
      .ring_i(ring), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .instr_o(instr), .state_o(state));

   sbt_tap_master u_master (
      .clock_i(clock_i), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck), .tms_o(tms), .tdi_o(tdi),
      .rx_valid_o(rx_valid), .rx_bit_o(rx_bit));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // tms bits taken lsb first
   task automatic mv(input logic [7:0] t, input int n);
      for (int i = 0; i < n; i++) begin
         u_master.step(t[i], 1'b1, 1'b0);
      end
   endtask

   // last bit leaves the shift state with tms high
   task automatic scan(input logic [127:0] din, input logic [127:0] exp, input logic [127:0] msk, input int n);
      for (int i = 0; i < n; i++) begin
         if (msk[i]) begin
            exp_q.push_back(exp[i]);
         end
         u_master.step(i == n - 1, din[i], msk[i]);
      end
   endtask

   task automatic load_ir(input logic [2:0] code);
      mv(8'h03, 4);
      scan({125'h0, code}, 128'h1, 128'h3, 3);
      mv(8'h01, 2);
      check(32'(instr), 32'(code));
   endtask

   // from run-idle: capture, shift len+8 bits, back to run-idle
   task automatic dr_test(input int len, input logic [127:0] cap);
      logic [127:0] din;
      logic [127:0] exp;
      din = {$urandom, $urandom, $urandom, $urandom};
      exp = cap;
      for (int i = 0; i < 8; i++) begin
         exp[len + i] = din[i];
      end
      mv(8'h01, 3);
      check(32'(state), 32'(SBT_SHIFT_DR));
      scan(din, exp, '1, len + 8);
      mv(8'h01, 2);
      check(32'(tdo_oe), 32'h0);
   endtask

   always @(posedge clock_i) begin
      if (rx_valid === 1'b1) begin
         check({31'h0, rx_bit}, {31'h0, exp_q.pop_front()});
      end
   end

   initial begin
      logic [2:0] code;
      void'($urandom(32'hD7C627CA));
      repeat (4) @(posedge clock_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      check(32'(state), 32'(SBT_TLR));
      check(32'(instr), 32'(SBT_INS_IDCODE));
      check(32'(tdo_oe), 32'h0);
      $display("test power_up done");
      mv(8'h00, 1);
      dr_test(SBT_ID_W, 128'(ID_VAL));
      $display("test default_id done");
      for (int c = 0; c < 8; c++) begin
         code = 3'(c);
         ring <= SBT_BSR_W'({$urandom, $urandom, $urandom, $urandom});
         load_ir(code);
         case (code)
            SBT_INS_EXTEST, SBT_INS_SAMPLE_Z, SBT_INS_SAMPLE: dr_test(SBT_BSR_W, 128'(ring));
            SBT_INS_IDCODE: dr_test(SBT_ID_W, 128'(ID_VAL));
            default: dr_test(1, 128'h0);
         endcase
         $display("test code %0d done", c);
      end
      load_ir(SBT_INS_BYPASS);
      // a whole tck pulse under a low clock enable must be lost
      ce_i <= 1'b0;
      mv(8'h01, 1);
      ce_i <= 1'b1;
      check(32'(state), 32'(SBT_RTI));
      check(32'(instr), 32'(SBT_INS_BYPASS));
      $display("test freeze done");
      mv(8'h01, 3);
      mv(8'h0F, 4);
      check(32'(state), 32'(SBT_SEL_IR));
      mv(8'h01, 1);
      check(32'(state), 32'(SBT_TLR));
      check(32'(instr), 32'(SBT_INS_IDCODE));
      check(32'(exp_q.size()), 32'h0);
      $display("test port_reset done");
      close_out();
   end

   // full run needs well under 0.5 ms of tck traffic
   initial begin
      #1000000;
      error_cnt++;
      close_out();
   end
endmodule // sbt_tap_test
